// *** bench/pin_model.sv ***
// Board-side pad model that resolves driven and undriven port pins
`timescale 1ns/1ps
module pin_model (
  // Pad control from the block
  input  wire gpio_pkg::pin_ctl_t ctl_i,
  // Level of the outside source
  input  wire logic [7:0]         ext_i,
  // Resolved pad level
  output logic [7:0]              pin_o
);
  // Driven bits show the latch; the outside source overpowers any pull
  assign pin_o = (ctl_i.oe & ctl_i.out) | (~ctl_i.oe & ext_i);
endmodule

// *** bench/tb_top.sv ***
// Register-level testbench for the port pin control block
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, ce_i, emu, lsg, lsh, crx, ctx, irq, tx_o, cv0;
  gpio_pkg::wb_req_t wb;
  gpio_pkg::op_mode_t mode;
  gpio_pkg::pin_ctl_t a_ctl, e_ctl, g_ctl;
  gpio_pkg::low_drive_t ld;
  logic [31:0] dat, q;
  logic ack;
  logic [7:0] a_ext, pa, pb, pe, g_ext, pg, ph, ad0;
  int mismatches, n_compared;

  port_pin_control u_port_pin_control (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_i(wb), .wb_dat_o(dat), .wb_ack_o(ack), .mode_i(mode),
    .external_porte_emulation_i(emu), .converter0_power_up_i(cv0),
    .converter1_power_up_i(1'b0), .porta_pin_i(pa), .porta_ctl_o(a_ctl),
    .portb_pin_i(pb), .portb_ctl_o(), .porte_pin_i(pe), .porte_ctl_o(e_ctl),
    .portg_pin_i(pg), .portg_load_select_pin_i(lsg), .portg_ctl_o(g_ctl),
    .porth_pin_i(ph), .porth_load_select_pin_i(lsh), .porth_ctl_o(),
    .can_receive_pin_i(crx), .can_transmit_pin_o(tx_o), .can_ctrl_tx_i(ctx),
    .can_ctrl_rx_o(), .ad0_pin_i(ad0), .ad1_pin_i(8'h3C), .low_drive_o(ld),
    .wake_irq_o(irq));
  pin_model u_pin_model_a (.ctl_i(a_ctl), .ext_i(a_ext), .pin_o(pa));
  pin_model u_pin_model_g (.ctl_i(g_ctl), .ext_i(g_ext), .pin_o(pg));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {24'h000000, d}};
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        finish_test();
      end
      @(posedge clk_i);
    end
    q = dat;
    wb <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  initial begin
    {emu, lsg, lsh, cv0, mismatches, n_compared} = '0;
    wb = '0;
    mode = gpio_pkg::MODE_SINGLE;
    {rst_i, ce_i, ctx, crx, a_ext, g_ext} = {2'b11, 2'b11, 8'hC3, 8'hFF};
    {pb, pe, ph, ad0} = {8'h00, 8'h03, 8'hFF, 8'hA5};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset state and analog port; pads are checked mid-cycle, once settled
    @(negedge clk_i);
    chk(a_ctl.oe, 8'h00);
    chk(tx_o, 1'b1);
    @(posedge clk_i);
    rd(gpio_pkg::OFS_PORTA_DIR, 8'h00);
    rd(gpio_pkg::OFS_AD0_DATA, 8'hA5);
    cv0 <= 1'b1;
    rd(gpio_pkg::OFS_AD0_DATA, 8'h00);
    $display("reset test done");
    // Mixed directions: driven bits read the latch, others the pin
    wr(gpio_pkg::OFS_PORTA_DIR, 8'h0F);
    wr(gpio_pkg::OFS_PORTA_DATA, 8'h5A);
    wr(gpio_pkg::OFS_PORTB_DIR, 8'h81);
    rd(gpio_pkg::OFS_PORTA_DATA, 8'hCA);
    rd(gpio_pkg::OFS_PORTB_DIR, 8'h81);
    wr(gpio_pkg::OFS_PULLUP, 8'h33);
    @(negedge clk_i);
    chk(a_ctl.oe, 8'h0F);
    chk(a_ctl.pull_up, 8'hF0);
    chk(e_ctl.pull_up, 8'h8F);
    chk(g_ctl.pull_down, 8'hFF);
    @(posedge clk_i);
    wr(gpio_pkg::OFS_PORTE_DIR, 8'hFF);
    rd(gpio_pkg::OFS_PORTE_DATA, 8'h03);
    @(negedge clk_i);
    chk(e_ctl.oe, 8'hFC);
    @(posedge clk_i);
    lsg <= 1'b1;
    wr(gpio_pkg::OFS_PORTE_FUNC, 8'h80);
    @(negedge clk_i);
    chk(e_ctl.oe, 8'h7C);
    chk(g_ctl.pull_up, 8'hFF);
    @(posedge clk_i);
    $display("direction test done");
    // Expanded mode hides A and B, and port E only while emulated
    mode <= gpio_pkg::MODE_EXPANDED;
    emu <= 1'b1;
    @(posedge clk_i);
    rd(gpio_pkg::OFS_PORTA_DATA, 8'h00);
    rd(gpio_pkg::OFS_PORTB_DIR, 8'h00);
    rd(gpio_pkg::OFS_PORTE_DIR, 8'h00);
    emu <= 1'b0;
    rd(gpio_pkg::OFS_PORTE_DIR, 8'hFF);
    @(negedge clk_i);
    chk(a_ctl.pull_up, 8'h00);
    @(posedge clk_i);
    // Peripheral mode hides port E; a drive write there must not lock
    mode <= gpio_pkg::MODE_PERIPH;
    wr(gpio_pkg::OFS_RDRIVE, 8'h70);
    rd(gpio_pkg::OFS_PORTE_DIR, 8'h00);
    mode <= gpio_pkg::MODE_SINGLE;
    $display("mode test done");
    // Reduced drive takes only the first mapped write
    wr(gpio_pkg::OFS_RDRIVE, 8'h01);
    wr(gpio_pkg::OFS_RDRIVE, 8'h70);
    rd(gpio_pkg::OFS_RDRIVE, 8'h01);
    @(negedge clk_i);
    chk(ld, 5'b10000);
    @(posedge clk_i);
    mode <= gpio_pkg::MODE_PERIPH;
    rd(gpio_pkg::OFS_RDRIVE, 8'h00);
    mode <= gpio_pkg::MODE_SINGLE;
    $display("drive test done");
    // Wake-up falling edge, sticky flag, clear, then an unenabled pin
    wr(gpio_pkg::OFS_PORTG_IEN, 8'h01);
    g_ext <= 8'hFE;
    repeat (2) @(posedge clk_i);
    rd(gpio_pkg::OFS_PORTG_FLAG, 8'h01);
    g_ext <= 8'hFF;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(irq, 1'b1);
    @(posedge clk_i);
    wr(gpio_pkg::OFS_PORTG_FLAG, 8'h01);
    g_ext <= 8'hFD;
    repeat (2) @(posedge clk_i);
    rd(gpio_pkg::OFS_PORTG_FLAG, 8'h02);
    @(negedge clk_i);
    chk(irq, 1'b0);
    @(posedge clk_i);
    $display("wake test done");
    // CAN placement and dominant level; pins are registered one cycle
    ctx <= 1'b0;
    @(posedge clk_i);
    rd(gpio_pkg::OFS_CAN_DATA, 8'h01);
    @(negedge clk_i);
    chk(tx_o, 1'b0);
    $display("can test done");
    finish_test();
  end
endmodule

// *** logic/gpio_pkg.sv ***
// Shared constants, modes and carrier structs for the port pin control block
package gpio_pkg;

  // Operating mode of the device, driven by mode logic outside this block
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_PERIPH
  } op_mode_t;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_PORTA_DATA = 8'h00;
  localparam logic [7:0] OFS_PORTA_DIR  = 8'h04;
  localparam logic [7:0] OFS_PORTB_DATA = 8'h08;
  localparam logic [7:0] OFS_PORTB_DIR  = 8'h0C;
  localparam logic [7:0] OFS_PORTE_DATA = 8'h10;
  localparam logic [7:0] OFS_PORTE_DIR  = 8'h14;
  localparam logic [7:0] OFS_PORTE_FUNC = 8'h18;
  localparam logic [7:0] OFS_PULLUP     = 8'h1C;
  localparam logic [7:0] OFS_RDRIVE     = 8'h20;
  localparam logic [7:0] OFS_PORTG_DATA = 8'h24;
  localparam logic [7:0] OFS_PORTG_DIR  = 8'h28;
  localparam logic [7:0] OFS_PORTH_DATA = 8'h2C;
  localparam logic [7:0] OFS_PORTH_DIR  = 8'h30;
  localparam logic [7:0] OFS_PORTG_FLAG = 8'h34;
  localparam logic [7:0] OFS_PORTG_IEN  = 8'h38;
  localparam logic [7:0] OFS_PORTH_FLAG = 8'h3C;
  localparam logic [7:0] OFS_PORTH_IEN  = 8'h40;
  localparam logic [7:0] OFS_CAN_DATA   = 8'h44;
  localparam logic [7:0] OFS_AD0_DATA   = 8'h48;
  localparam logic [7:0] OFS_AD1_DATA   = 8'h4C;

  // Bit positions shared by the pull-up and reduced-drive registers
  localparam int BIT_A = 0;
  localparam int BIT_B = 1;
  localparam int BIT_E = 4;
  localparam int BIT_G = 5;
  localparam int BIT_H = 6;

  // CAN port bit positions
  localparam int CAN_RX_BIT = 0;
  localparam int CAN_TX_BIT = 1;

  // Reset values
  localparam logic [7:0] DIR_RST   = 8'h00;
  localparam logic [7:0] OUT_RST   = 8'h00;
  localparam logic [7:0] PULL_RST  = 8'h00;
  localparam logic [7:0] RDRV_RST  = 8'h00;
  localparam logic [7:0] FUNC_RST  = 8'h00;
  localparam logic [7:0] FLAG_RST  = 8'h00;
  localparam logic [7:0] IEN_RST   = 8'h00;
  localparam logic [7:0] PREV_RST  = 8'hFF;

  // Port masks
  localparam logic [7:0] ALL_MASK    = 8'hFF;
  localparam logic [7:0] PE_DIR_MASK = 8'hFC;
  localparam logic [7:0] PE_PU_MASK  = 8'h8F;

  // Per-port pad control
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } pin_ctl_t;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // Reduced-drive outputs per port
  typedef struct packed {
    logic a;
    logic b;
    logic e;
    logic g;
    logic h;
  } low_drive_t;

endpackage

// *** logic/key_wake.sv ***
// Key wake-up edge detector with sticky flags and interrupt enables
`timescale 1ns/1ps
module key_wake (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Register writes
  input  wire logic       wr_flag_i,
  input  wire logic       wr_ien_i,
  input  wire logic [7:0] wdata_i,
  // Pins and status
  input  wire logic [7:0] pin_i,
  output logic [7:0]      flag_o,
  output logic [7:0]      ien_o,
  output logic            irq_o
);

  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] flag;
    logic [7:0] ien;
  } wake_state_t;

  wake_state_t st_reg;
  wake_state_t st_next;
  logic [7:0]  fall;
  logic [7:0]  clr;

  assign fall = st_reg.prev & ~pin_i;
  assign clr  = wr_flag_i ? wdata_i : 8'h00;

  // Write one clears a flag; a new edge in that cycle wins
  always_comb begin
    st_next      = st_reg;
    st_next.prev = pin_i;
    st_next.flag = (st_reg.flag & ~clr) | fall;
    if (wr_ien_i) begin
      st_next.ien = wdata_i;
    end
  end

  // Previous level resets high, so a pin held low at reset release sets its flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{prev: gpio_pkg::PREV_RST, flag: gpio_pkg::FLAG_RST,
                  ien: gpio_pkg::IEN_RST};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign flag_o = st_reg.flag;
  assign ien_o  = st_reg.ien;
  assign irq_o  = |(st_reg.flag & st_reg.ien);

  a_fall_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && fall != 8'h00) |=> (flag_o & $past(fall)) == $past(fall))
    else $error("falling edge did not set flag");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !wr_flag_i) |=> (flag_o & $past(flag_o)) == $past(flag_o))
    else $error("flag dropped without a clear");

endmodule

// *** logic/port_cell.sv ***
// One 8-bit general-purpose port: output latch, direction and pull control
`timescale 1ns/1ps
module port_cell (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Register writes
  input  wire logic              wr_data_i,
  input  wire logic              wr_dir_i,
  input  wire logic [7:0]        wdata_i,
  // Configuration
  input  wire logic [7:0]        dir_mask_i,
  input  wire logic [7:0]        pull_mask_i,
  input  wire logic              gp_en_i,
  input  wire logic              pull_en_i,
  input  wire logic              pull_up_sel_i,
  // Pins and read-back
  input  wire logic [7:0]        pin_i,
  output logic [7:0]             rdata_o,
  output logic [7:0]             dir_o,
  output gpio_pkg::pin_ctl_t     ctl_o
);

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
  } cell_state_t;

  cell_state_t st_reg;
  cell_state_t st_next;
  logic [7:0]  oe;
  logic [7:0]  pull;

  // Next state: writes touch the latch or direction only
  always_comb begin
    st_next = st_reg;
    if (wr_data_i) begin
      st_next.out = wdata_i;
    end
    if (wr_dir_i) begin
      st_next.dir = wdata_i;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{out: gpio_pkg::OUT_RST, dir: gpio_pkg::DIR_RST};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Pad drive; masked pins never drive
  assign oe   = st_reg.dir & dir_mask_i & {8{gp_en_i}};
  // Loads apply to input pins only
  assign pull = ~oe & pull_mask_i & {8{pull_en_i & gp_en_i}};
  assign ctl_o.out       = st_reg.out;
  assign ctl_o.oe        = oe;
  assign ctl_o.pull_up   = pull & {8{pull_up_sel_i}};
  assign ctl_o.pull_down = pull & ~{8{pull_up_sel_i}};
  assign dir_o   = st_reg.dir;
  // Inputs show the pin, outputs the latch
  assign rdata_o = (pin_i & ~oe) | (st_reg.out & oe);

  a_reset_all_inputs: assert property (@(posedge clk_i) rst_i |=> ctl_o.oe == 8'h00)
    else $error("pins not inputs after reset");
  a_write_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr_data_i) |=> ctl_o.out == $past(wdata_i))
    else $error("output latch missed a write");

endmodule

// *** logic/port_pin_control.sv ***
// Port data, direction, pull and wake-up registers behind a Wishbone slave
`timescale 1ns/1ps
module port_pin_control (
  // Clock, reset, enable
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  // Wishbone slave
  input  wire gpio_pkg::wb_req_t   wb_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  // Mode inputs
  input  wire gpio_pkg::op_mode_t  mode_i,
  input  wire logic                external_porte_emulation_i,
  input  wire logic                converter0_power_up_i,
  input  wire logic                converter1_power_up_i,
  // Port A, B, E pins
  input  wire logic [7:0]          porta_pin_i,
  output gpio_pkg::pin_ctl_t       porta_ctl_o,
  input  wire logic [7:0]          portb_pin_i,
  output gpio_pkg::pin_ctl_t       portb_ctl_o,
  input  wire logic [7:0]          porte_pin_i,
  output gpio_pkg::pin_ctl_t       porte_ctl_o,
  // Port G, H pins
  input  wire logic [7:0]          portg_pin_i,
  input  wire logic                portg_load_select_pin_i,
  output gpio_pkg::pin_ctl_t       portg_ctl_o,
  input  wire logic [7:0]          porth_pin_i,
  input  wire logic                porth_load_select_pin_i,
  output gpio_pkg::pin_ctl_t       porth_ctl_o,
  // CAN pins and controller side
  input  wire logic                can_receive_pin_i,
  output logic                     can_transmit_pin_o,
  input  wire logic                can_ctrl_tx_i,
  output logic                     can_ctrl_rx_o,
  // Analog input ports
  input  wire logic [7:0]          ad0_pin_i,
  input  wire logic [7:0]          ad1_pin_i,
  // Drive level and wake-up interrupt
  output gpio_pkg::low_drive_t     low_drive_o,
  output logic                     wake_irq_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  pullup_control_reg;
    logic [7:0]  reduced_drive_reg;
    logic        rdrv_written;
    logic [7:0]  porte_function_select;
    logic        can_tx;
    logic        can_rx;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  // Bus strobes
  logic       req;
  logic       wr;
  logic       map_ab;
  logic       map_e;
  logic       map_rdrv;
  logic       hit;
  logic [7:0] rd_byte;
  logic [7:0] wd;

  // Read-back and control from the port cells
  logic [7:0] a_rd, a_dir, b_rd, b_dir, e_rd, e_dir;
  logic [7:0] g_rd, g_dir, h_rd, h_dir;
  logic [7:0] g_flag, g_ien, h_flag, h_ien;
  logic       g_irq, h_irq;
  logic [7:0] pe_mask;

  // Write strobes per register
  logic wr_a_d, wr_a_r, wr_b_d, wr_b_r, wr_e_d, wr_e_r;
  logic wr_g_d, wr_g_r, wr_h_d, wr_h_r;
  logic wr_g_f, wr_g_i, wr_h_f, wr_h_i;

  // One request per cycle; ack blocks a second take
  assign req = wb_i.cyc & wb_i.stb & ~st_reg.ack;
  assign wr  = req & wb_i.we & wb_i.sel[0];
  assign wd  = wb_i.dat[7:0];

  // Address map depends on operating mode
  assign map_ab   = (mode_i == gpio_pkg::MODE_SINGLE);
  assign map_e    = (mode_i == gpio_pkg::MODE_SINGLE) ||
                    (mode_i == gpio_pkg::MODE_EXPANDED &&
                     !external_porte_emulation_i);
  assign map_rdrv = (mode_i != gpio_pkg::MODE_PERIPH);

  // Decoded writes, ignored while the register is out of the map
  assign wr_a_d = wr & map_ab & (wb_i.adr == gpio_pkg::OFS_PORTA_DATA);
  assign wr_a_r = wr & map_ab & (wb_i.adr == gpio_pkg::OFS_PORTA_DIR);
  assign wr_b_d = wr & map_ab & (wb_i.adr == gpio_pkg::OFS_PORTB_DATA);
  assign wr_b_r = wr & map_ab & (wb_i.adr == gpio_pkg::OFS_PORTB_DIR);
  assign wr_e_d = wr & map_e & (wb_i.adr == gpio_pkg::OFS_PORTE_DATA);
  assign wr_e_r = wr & map_e & (wb_i.adr == gpio_pkg::OFS_PORTE_DIR);
  assign wr_g_d = wr & (wb_i.adr == gpio_pkg::OFS_PORTG_DATA);
  assign wr_g_r = wr & (wb_i.adr == gpio_pkg::OFS_PORTG_DIR);
  assign wr_h_d = wr & (wb_i.adr == gpio_pkg::OFS_PORTH_DATA);
  assign wr_h_r = wr & (wb_i.adr == gpio_pkg::OFS_PORTH_DIR);
  assign wr_g_f = wr & (wb_i.adr == gpio_pkg::OFS_PORTG_FLAG);
  assign wr_g_i = wr & (wb_i.adr == gpio_pkg::OFS_PORTG_IEN);
  assign wr_h_f = wr & (wb_i.adr == gpio_pkg::OFS_PORTH_FLAG);
  assign wr_h_i = wr & (wb_i.adr == gpio_pkg::OFS_PORTH_IEN);

  // Function select wins over direction; PE1:0 never drive
  assign pe_mask = gpio_pkg::PE_DIR_MASK & ~st_reg.porte_function_select;

  // Port A and B: general I/O and pulls only in single chip
  port_cell u_porta (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .wr_data_i     (wr_a_d),
    .wr_dir_i      (wr_a_r),
    .wdata_i       (wd),
    .dir_mask_i    (gpio_pkg::ALL_MASK),
    .pull_mask_i   (gpio_pkg::ALL_MASK),
    .gp_en_i       (map_ab),
    .pull_en_i     (st_reg.pullup_control_reg[gpio_pkg::BIT_A]),
    .pull_up_sel_i (1'b1),
    .pin_i         (porta_pin_i),
    .rdata_o       (a_rd),
    .dir_o         (a_dir),
    .ctl_o         (porta_ctl_o)
  );

  port_cell u_portb (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .wr_data_i     (wr_b_d),
    .wr_dir_i      (wr_b_r),
    .wdata_i       (wd),
    .dir_mask_i    (gpio_pkg::ALL_MASK),
    .pull_mask_i   (gpio_pkg::ALL_MASK),
    .gp_en_i       (map_ab),
    .pull_en_i     (st_reg.pullup_control_reg[gpio_pkg::BIT_B]),
    .pull_up_sel_i (1'b1),
    .pin_i         (portb_pin_i),
    .rdata_o       (b_rd),
    .dir_o         (b_dir),
    .ctl_o         (portb_ctl_o)
  );

  // Port E: pulls on PE7 and PE3:0 only
  port_cell u_porte (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .wr_data_i     (wr_e_d),
    .wr_dir_i      (wr_e_r),
    .wdata_i       (wd),
    .dir_mask_i    (pe_mask),
    .pull_mask_i   (gpio_pkg::PE_PU_MASK),
    .gp_en_i       (map_e),
    .pull_en_i     (st_reg.pullup_control_reg[gpio_pkg::BIT_E]),
    .pull_up_sel_i (1'b1),
    .pin_i         (porte_pin_i),
    .rdata_o       (e_rd),
    .dir_o         (e_dir),
    .ctl_o         (porte_ctl_o)
  );

  // Port G and H: load type follows the select pin
  port_cell u_portg (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .wr_data_i     (wr_g_d),
    .wr_dir_i      (wr_g_r),
    .wdata_i       (wd),
    .dir_mask_i    (gpio_pkg::ALL_MASK),
    .pull_mask_i   (gpio_pkg::ALL_MASK),
    .gp_en_i       (1'b1),
    .pull_en_i     (st_reg.pullup_control_reg[gpio_pkg::BIT_G]),
    .pull_up_sel_i (portg_load_select_pin_i),
    .pin_i         (portg_pin_i),
    .rdata_o       (g_rd),
    .dir_o         (g_dir),
    .ctl_o         (portg_ctl_o)
  );

  port_cell u_porth (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .wr_data_i     (wr_h_d),
    .wr_dir_i      (wr_h_r),
    .wdata_i       (wd),
    .dir_mask_i    (gpio_pkg::ALL_MASK),
    .pull_mask_i   (gpio_pkg::ALL_MASK),
    .gp_en_i       (1'b1),
    .pull_en_i     (st_reg.pullup_control_reg[gpio_pkg::BIT_H]),
    .pull_up_sel_i (porth_load_select_pin_i),
    .pin_i         (porth_pin_i),
    .rdata_o       (h_rd),
    .dir_o         (h_dir),
    .ctl_o         (porth_ctl_o)
  );

  // Wake-up sees the pin in either direction
  key_wake u_wake_g (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wr_flag_i (wr_g_f),
    .wr_ien_i  (wr_g_i),
    .wdata_i   (wd),
    .pin_i     (portg_pin_i),
    .flag_o    (g_flag),
    .ien_o     (g_ien),
    .irq_o     (g_irq)
  );

  key_wake u_wake_h (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .wr_flag_i (wr_h_f),
    .wr_ien_i  (wr_h_i),
    .wdata_i   (wd),
    .pin_i     (porth_pin_i),
    .flag_o    (h_flag),
    .ien_o     (h_ien),
    .irq_o     (h_irq)
  );

  assign wake_irq_o = g_irq | h_irq;

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_byte = 8'h00;
    hit     = 1'b1;
    unique case (wb_i.adr)
      gpio_pkg::OFS_PORTA_DATA: rd_byte = map_ab ? a_rd : 8'h00;
      gpio_pkg::OFS_PORTA_DIR:  rd_byte = map_ab ? a_dir : 8'h00;
      gpio_pkg::OFS_PORTB_DATA: rd_byte = map_ab ? b_rd : 8'h00;
      gpio_pkg::OFS_PORTB_DIR:  rd_byte = map_ab ? b_dir : 8'h00;
      gpio_pkg::OFS_PORTE_DATA: rd_byte = map_e ? e_rd : 8'h00;
      gpio_pkg::OFS_PORTE_DIR:  rd_byte = map_e ? e_dir : 8'h00;
      gpio_pkg::OFS_PORTE_FUNC: rd_byte = st_reg.porte_function_select;
      gpio_pkg::OFS_PULLUP:     rd_byte = st_reg.pullup_control_reg;
      gpio_pkg::OFS_RDRIVE:     rd_byte = map_rdrv ? st_reg.reduced_drive_reg : 8'h00;
      gpio_pkg::OFS_PORTG_DATA: rd_byte = g_rd;
      gpio_pkg::OFS_PORTG_DIR:  rd_byte = g_dir;
      gpio_pkg::OFS_PORTH_DATA: rd_byte = h_rd;
      gpio_pkg::OFS_PORTH_DIR:  rd_byte = h_dir;
      gpio_pkg::OFS_PORTG_FLAG: rd_byte = g_flag;
      gpio_pkg::OFS_PORTG_IEN:  rd_byte = g_ien;
      gpio_pkg::OFS_PORTH_FLAG: rd_byte = h_flag;
      gpio_pkg::OFS_PORTH_IEN:  rd_byte = h_ien;
      // Lower two CAN pins belong to the CAN controller; upper six read zero
      gpio_pkg::OFS_CAN_DATA: begin
        rd_byte[gpio_pkg::CAN_RX_BIT] = st_reg.can_rx;
        rd_byte[gpio_pkg::CAN_TX_BIT] = st_reg.can_tx;
      end
      // Converter owns the pins once powered
      gpio_pkg::OFS_AD0_DATA:   rd_byte = converter0_power_up_i ? 8'h00 : ad0_pin_i;
      gpio_pkg::OFS_AD1_DATA:   rd_byte = converter1_power_up_i ? 8'h00 : ad1_pin_i;
      default:                  hit = 1'b0;
    endcase
  end

  // Control registers and bus answer
  always_comb begin
    st_next        = st_reg;
    st_next.ack    = req;
    st_next.rdata  = (req && !wb_i.we && hit) ? {24'h000000, rd_byte} : 32'h00000000;
    st_next.can_tx = can_ctrl_tx_i;
    st_next.can_rx = can_receive_pin_i;
    if (wr && wb_i.adr == gpio_pkg::OFS_PORTE_FUNC) begin
      st_next.porte_function_select = wd;
    end
    if (wr && wb_i.adr == gpio_pkg::OFS_PULLUP) begin
      st_next.pullup_control_reg = wd;
    end
    // Later writes are dropped to guard drive settings
    if (wr && map_rdrv && !st_reg.rdrv_written && wb_i.adr == gpio_pkg::OFS_RDRIVE) begin
      st_next.reduced_drive_reg = wd;
      st_next.rdrv_written      = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{ack: 1'b0, rdata: 32'h00000000,
                  pullup_control_reg: gpio_pkg::PULL_RST,
                  reduced_drive_reg: gpio_pkg::RDRV_RST, rdrv_written: 1'b0,
                  porte_function_select: gpio_pkg::FUNC_RST,
                  can_tx: 1'b1, can_rx: 1'b1};
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o           = st_reg.ack;
  assign wb_dat_o           = st_reg.rdata;
  assign can_transmit_pin_o = st_reg.can_tx;
  assign can_ctrl_rx_o      = st_reg.can_rx;
  // Whole-port drive reduction
  assign low_drive_o.a = st_reg.reduced_drive_reg[gpio_pkg::BIT_A];
  assign low_drive_o.b = st_reg.reduced_drive_reg[gpio_pkg::BIT_B];
  assign low_drive_o.e = st_reg.reduced_drive_reg[gpio_pkg::BIT_E];
  assign low_drive_o.g = st_reg.reduced_drive_reg[gpio_pkg::BIT_G];
  assign low_drive_o.h = st_reg.reduced_drive_reg[gpio_pkg::BIT_H];

  a_ack_then_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req) |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i)))
    else $error("ack not a single cycle pulse");
  a_rdrv_write_once: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg.rdrv_written |=> $stable(st_reg.reduced_drive_reg))
    else $error("reduced drive changed after first write");
  a_ab_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_i != gpio_pkg::MODE_SINGLE) |-> (porta_ctl_o.oe | portb_ctl_o.oe) == 8'h00)
    else $error("port A or B drives outside single chip");
  a_pe_low_input: assert property (@(posedge clk_i) disable iff (rst_i)
    porte_ctl_o.oe[1:0] == 2'b00 && porte_ctl_o.pull_up[6:4] == 3'b000)
    else $error("port E low pins drive or bad pull");
  a_can_tx_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> can_transmit_pin_o == $past(can_ctrl_tx_i))
    else $error("CAN transmit pin lost controller level");
  a_e_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req && !wb_i.we && !map_e && wb_i.adr == gpio_pkg::OFS_PORTE_DATA)
    |=> wb_dat_o == 32'h00000000)
    else $error("port E readable while unmapped");

endmodule
